// >>> verilog/cdc_pkg.sv
// What this block does
// R1 - outside latch on: per-axis outside flags hold until outside source read
// R2 - outside latch on: outside event active only on false-to-true transition
// R3 - outside latch off: per-axis outside flags follow condition each evaluation
// R4 - inside latch on: per-axis inside flags hold until inside source read
// R5 - inside latch off: per-axis inside flags follow condition each evaluation
// R6 - inside latch on: inside event active only on false-to-true transition
// R7 - outside axis selects at config_a bits 5,4,3 gate x,y,z
// R8 - inside axis selects at config_a bits 2,1,0 gate x,y,z
// R9 - reset values depend on boot pin: zero when low, documented set when high
// R10 - detector_on low disables the detector and gates its clock
// R11 - detector_on resets to one only with boot pin high and motion option set
// R12 - setting detector_on initialises 12-bit references per update policy
// R13 - inside combine bit 2: zero selects AND, one selects OR
// R14 - update policy 11b uses zero references, absolute comparison
// R15 - no inside axis selected means inside event never asserts
// R16 - config changes take effect at the next output-data-rate evaluation; here shadows load at the next tick and are used from the evaluation after it
package cdc_pkg;
	localparam logic [7:0] CDC_CONFIG_A_ADDR = 8'h2f;
	localparam logic [7:0] CDC_CONFIG_B_ADDR = 8'h30;
	localparam logic [7:0] CDC_CONFIG_A_RST_LOW = 8'h00;
	localparam logic [7:0] CDC_CONFIG_A_RST_HIGH = 8'h38;
	localparam logic [7:0] CDC_CONFIG_B_RST_LOW = 8'h00;
	localparam logic [7:0] CDC_CONFIG_B_RST_HIGH = 8'hd8;
	localparam int CDC_OUT_LATCH_BIT = 7;
	localparam int CDC_IN_LATCH_BIT = 6;
	localparam int CDC_OUT_SEL_LSB = 3;
	localparam int CDC_IN_SEL_LSB = 0;
	localparam int CDC_ON_BIT = 7;
	localparam int CDC_POLICY_LSB = 5;
	localparam int CDC_COMBINE_BIT = 2;
	localparam logic [1:0] CDC_POLICY_ABSOLUTE = 2'h3;
	localparam int CDC_REF_W = 12;
	typedef struct packed {
		logic [7:0] config_a;
		logic [7:0] config_b;
		logic [2:0] out_sel;
		logic [2:0] in_sel;
		logic out_latch;
		logic in_latch;
		logic in_or;
		logic [2:0] out_flags;
		logic [2:0] in_flags;
		logic out_active;
		logic in_active;
		logic out_cond_prev;
		logic in_cond_prev;
		logic [CDC_REF_W-1:0] ref_x;
		logic [CDC_REF_W-1:0] ref_y;
		logic [CDC_REF_W-1:0] ref_z;
		logic [7:0] rdata;
	} cdc_state_type;
	typedef struct packed {
		logic [2:0] outside_hit;
		logic [2:0] inside_hit;
		logic [CDC_REF_W-1:0] x;
		logic [CDC_REF_W-1:0] y;
		logic [CDC_REF_W-1:0] z;
	} cdc_eval_type;
endpackage

// >>> verilog/cdc_config.sv
`timescale 1ns/1ps
module cdc_config (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic boot_config_pin_in,
	input wire logic motion_detect_boot_option_in,
	input wire logic odr_tick_in,
	input wire cdc_pkg::cdc_eval_type eval_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic outside_source_read_in,
	input wire logic inside_source_read_in,
	output logic [7:0] rdata_out,
	output logic detector_clk_en_out,
	output logic outside_event_active_out,
	output logic inside_event_active_out,
	output logic [2:0] per_axis_outside_flags_out,
	output logic [2:0] per_axis_inside_flags_out,
	output logic [35:0] reference_out
);
	import cdc_pkg::*;
	cdc_state_type s_reg, s_next;
	logic out_cond, in_cond, on_rise, eval;
	logic [7:0] rst_a, rst_b;

	function automatic logic combine(input logic [2:0] hit, input logic [2:0] sel, input logic use_or);
		combine = (sel == 3'h0) ? 1'b0 : (use_or ? |(hit & sel) : &(hit | ~sel));
	endfunction

	always_comb begin
		rst_a = boot_config_pin_in ? CDC_CONFIG_A_RST_HIGH : CDC_CONFIG_A_RST_LOW; // R9
		rst_b = CDC_CONFIG_B_RST_LOW;
		if (boot_config_pin_in) begin
			rst_b = CDC_CONFIG_B_RST_HIGH;
			rst_b[CDC_ON_BIT] = motion_detect_boot_option_in; // R11
		end
		eval = odr_tick_in && s_reg.config_b[CDC_ON_BIT]; // R10
		out_cond = combine(eval_in.outside_hit, s_reg.out_sel, 1'b1); // R7
		in_cond = combine(eval_in.inside_hit, s_reg.in_sel, s_reg.in_or); // R8 R13 R15
		on_rise = wr_en_in && addr_in == CDC_CONFIG_B_ADDR && wdata_in[CDC_ON_BIT]
			&& !s_reg.config_b[CDC_ON_BIT];
		s_next = s_reg;
		s_next.rdata = 8'h00;
		if (rd_en_in) begin
			if (addr_in == CDC_CONFIG_A_ADDR)
				s_next.rdata = s_reg.config_a;
			else if (addr_in == CDC_CONFIG_B_ADDR)
				s_next.rdata = s_reg.config_b;
		end
		if (wr_en_in && addr_in == CDC_CONFIG_A_ADDR)
			s_next.config_a = wdata_in;
		if (wr_en_in && addr_in == CDC_CONFIG_B_ADDR)
			s_next.config_b = wdata_in;
		// shadows load at every output-data-rate tick, detector on or off, so one in flight sees stable settings
		if (odr_tick_in) begin // R16
			s_next.out_sel = s_reg.config_a[CDC_OUT_SEL_LSB +: 3];
			s_next.in_sel = s_reg.config_a[CDC_IN_SEL_LSB +: 3];
			s_next.out_latch = s_reg.config_a[CDC_OUT_LATCH_BIT];
			s_next.in_latch = s_reg.config_a[CDC_IN_LATCH_BIT];
			s_next.in_or = s_reg.config_b[CDC_COMBINE_BIT];
		end
		if (outside_source_read_in)
			s_next.out_flags = 3'h0; // R1
		if (inside_source_read_in)
			s_next.in_flags = 3'h0; // R4
		if (eval) begin
			s_next.out_cond_prev = out_cond;
			s_next.in_cond_prev = in_cond;
			if (s_reg.out_latch) begin
				s_next.out_active = out_cond && !s_reg.out_cond_prev; // R2
				if (out_cond && !s_reg.out_cond_prev)
					s_next.out_flags = s_next.out_flags | (eval_in.outside_hit & s_reg.out_sel); // R1
			end else begin
				s_next.out_active = out_cond;
				s_next.out_flags = eval_in.outside_hit & s_reg.out_sel; // R3
			end
			if (s_reg.in_latch) begin
				s_next.in_active = in_cond && !s_reg.in_cond_prev; // R6
				if (in_cond && !s_reg.in_cond_prev)
					s_next.in_flags = s_next.in_flags | (eval_in.inside_hit & s_reg.in_sel); // R4
			end else begin
				s_next.in_active = in_cond;
				s_next.in_flags = eval_in.inside_hit & s_reg.in_sel; // R5
			end
		end
		// the policy written with the enable applies, so one write can arm absolute mode
		if (on_rise) begin // R12
			if (wdata_in[CDC_POLICY_LSB +: 2] == CDC_POLICY_ABSOLUTE) begin
				s_next.ref_x = '0; // R14
				s_next.ref_y = '0;
				s_next.ref_z = '0;
			end else begin
				s_next.ref_x = eval_in.x;
				s_next.ref_y = eval_in.y;
				s_next.ref_z = eval_in.z;
			end
		end
		if (wr_en_in && addr_in == CDC_CONFIG_B_ADDR && !wdata_in[CDC_ON_BIT]) begin
			s_next.out_active = 1'b0; // R10
			s_next.in_active = 1'b0;
			s_next.out_cond_prev = 1'b0;
			s_next.in_cond_prev = 1'b0;
		end
	end

	// reset values track the strap, sampled with the clock, not under the reset
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s_reg <= '0;
			s_reg.config_a <= rst_a; // R9
			s_reg.config_b <= rst_b; // R11
			s_reg.out_sel <= rst_a[CDC_OUT_SEL_LSB +: 3];
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata_out = s_reg.rdata;
	assign detector_clk_en_out = s_reg.config_b[CDC_ON_BIT];
	assign outside_event_active_out = s_reg.out_active;
	assign inside_event_active_out = s_reg.in_active;
	assign per_axis_outside_flags_out = s_reg.out_flags;
	assign per_axis_inside_flags_out = s_reg.in_flags;
	assign reference_out = {s_reg.ref_x, s_reg.ref_y, s_reg.ref_z};

	out_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
		s_reg.out_latch && !outside_source_read_in && !wr_en_in |=> (s_reg.out_flags & $past(s_reg.out_flags)) == $past(s_reg.out_flags))
		else $error("latched outside flag dropped without read");
	out_rise_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
		$rose(s_reg.out_active) && $past(s_reg.out_latch) |-> !$past(s_reg.out_cond_prev))
		else $error("outside event without false-to-true transition");
	out_live_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R3
		eval && !s_reg.out_latch && !outside_source_read_in |=> s_reg.out_flags == $past(eval_in.outside_hit & s_reg.out_sel))
		else $error("live outside flags wrong");
	in_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
		s_reg.in_latch && !inside_source_read_in |=> (s_reg.in_flags & $past(s_reg.in_flags)) == $past(s_reg.in_flags))
		else $error("latched inside flag dropped without read");
	in_live_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R5
		eval && !s_reg.in_latch && !inside_source_read_in |=> s_reg.in_flags == $past(eval_in.inside_hit & s_reg.in_sel))
		else $error("live inside flags wrong");
	in_rise_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R6
		$rose(s_reg.in_active) && $past(s_reg.in_latch) |-> !$past(s_reg.in_cond_prev))
		else $error("inside event without false-to-true transition");
	in_none_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R15
		eval && s_reg.in_sel == 3'h0 && !wr_en_in |=> !s_reg.in_active)
		else $error("inside event with no axis selected");
	off_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R10
		!s_reg.config_b[CDC_ON_BIT] && !wr_en_in |=> $stable(s_reg.out_active) && $stable(s_reg.in_active))
		else $error("detector changed state while off");
	abs_ref_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R14
		on_rise && wdata_in[CDC_POLICY_LSB +: 2] == CDC_POLICY_ABSOLUTE |=> reference_out == 36'h0)
		else $error("absolute policy left nonzero reference");

	// axis gating and combine
	out_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
		eval && !s_reg.out_latch |=> (per_axis_outside_flags_out & ~$past(s_reg.out_sel)) == 3'h0)
		else $error("unselected outside axis flagged");
	out_or_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
		eval && !s_reg.out_latch && (eval_in.outside_hit & s_reg.out_sel) != 3'h0 && !wr_en_in
			|=> outside_event_active_out)
		else $error("selected outside hit did not raise the event");
	out_none_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
		eval && s_reg.out_sel == 3'h0 && !s_reg.out_latch |=> !outside_event_active_out)
		else $error("outside event with no axis selected");
	in_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R8
		eval && !s_reg.in_latch |=> (per_axis_inside_flags_out & ~$past(s_reg.in_sel)) == 3'h0)
		else $error("unselected inside axis flagged");
	in_and_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R13
		eval && !s_reg.in_or && !s_reg.in_latch && (eval_in.inside_hit & s_reg.in_sel) != s_reg.in_sel
			|=> !inside_event_active_out)
		else $error("inside and-combine fired on a partial hit");
	in_or_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R13
		eval && s_reg.in_or && !s_reg.in_latch && (eval_in.inside_hit & s_reg.in_sel) != 3'h0 && !wr_en_in
			|=> inside_event_active_out)
		else $error("inside or-combine missed a hit");
	in_none_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R15
		eval && s_reg.in_sel == 3'h0 && !s_reg.in_latch |=> per_axis_inside_flags_out == 3'h0)
		else $error("inside flag with no axis selected");

	// a read clear that meets a new event in one cycle loses to the event
	out_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
		outside_source_read_in && !eval |=> per_axis_outside_flags_out == 3'h0)
		else $error("outside source read left flags set");
	in_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
		inside_source_read_in && !eval |=> per_axis_inside_flags_out == 3'h0)
		else $error("inside source read left flags set");
	out_set_wins_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
		eval && s_reg.out_latch && out_cond && !s_reg.out_cond_prev
			|=> (~per_axis_outside_flags_out & $past(eval_in.outside_hit & s_reg.out_sel)) == 3'h0)
		else $error("latched outside event not flagged");
	in_set_wins_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R4
		eval && s_reg.in_latch && in_cond && !s_reg.in_cond_prev
			|=> (~per_axis_inside_flags_out & $past(eval_in.inside_hit & s_reg.in_sel)) == 3'h0)
		else $error("latched inside event not flagged");

	// latched mode rearms only after the condition drops or the detector is switched off
	out_rearm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
		eval && s_reg.out_latch && s_reg.out_cond_prev |=> !outside_event_active_out)
		else $error("outside event retriggered without a drop");
	in_rearm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R6
		eval && s_reg.in_latch && s_reg.in_cond_prev |=> !inside_event_active_out)
		else $error("inside event retriggered without a drop");
	off_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R10
		wr_en_in && addr_in == CDC_CONFIG_B_ADDR && !wdata_in[CDC_ON_BIT]
			|=> !outside_event_active_out && !inside_event_active_out && !detector_clk_en_out)
		else $error("switching off left the detector active");

	// references move only when the detector is switched on
	ref_capture_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
		on_rise && wdata_in[CDC_POLICY_LSB +: 2] != CDC_POLICY_ABSOLUTE
			|=> reference_out == $past({eval_in.x, eval_in.y, eval_in.z}))
		else $error("references not captured at enable");
	ref_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
		!on_rise |=> $stable(reference_out))
		else $error("references moved without an enable");

	// reset values come from the strap at each clock edge with reset high
	reset_cfga_a: assert property (@(posedge ref_clk_in) // R9
		rst_in |=> s_reg.config_a == ($past(boot_config_pin_in) ? CDC_CONFIG_A_RST_HIGH : CDC_CONFIG_A_RST_LOW))
		else $error("first config register reset value wrong");
	reset_cfgb_a: assert property (@(posedge ref_clk_in) // R9
		rst_in |=> s_reg.config_b[CDC_ON_BIT-1:0] == ($past(boot_config_pin_in)
			? CDC_CONFIG_B_RST_HIGH[CDC_ON_BIT-1:0] : CDC_CONFIG_B_RST_LOW[CDC_ON_BIT-1:0]))
		else $error("second config register reset value wrong");
	reset_on_a: assert property (@(posedge ref_clk_in) // R11
		rst_in |=> s_reg.config_b[CDC_ON_BIT] == ($past(boot_config_pin_in) && $past(motion_detect_boot_option_in)))
		else $error("detector enable reset value wrong");

	// shadowed settings move only on a tick
	shadow_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R16
		odr_tick_in |=> {s_reg.out_latch, s_reg.in_latch, s_reg.out_sel, s_reg.in_sel, s_reg.in_or}
			== {$past(s_reg.config_a), $past(s_reg.config_b[CDC_COMBINE_BIT])})
		else $error("settings not shadowed at the tick");
	shadow_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R16
		!odr_tick_in |=> $stable({s_reg.out_latch, s_reg.in_latch, s_reg.out_sel, s_reg.in_sel, s_reg.in_or}))
		else $error("settings changed between ticks");
endmodule

// >>> verif/cdc_sensor_model.sv
`timescale 1ns/1ps
module cdc_sensor_model (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [5:0] hits_in,
	output logic odr_tick_out = 1'b0,
	output cdc_pkg::cdc_eval_type eval_out
);
	import cdc_pkg::*;
	logic [1:0] cnt_reg = 2'h0;
	// nonzero samples, so a zero reference after an enable can only come from the absolute policy
	assign eval_out = {hits_in, 12'h123, 12'h456, 12'h789};
	always @(posedge ref_clk_in) begin
		#1;
		cnt_reg <= rst_in ? 2'h0 : cnt_reg + 2'h1;
		odr_tick_out <= !rst_in && cnt_reg == 2'h2;
	end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cdc_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic boot = 1'b0;
	logic mot = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic osrc = 1'b0;
	logic isrc = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [5:0] hits = 6'h00;
	logic tick, clk_en, oact, iact;
	logic [2:0] oflg, iflg;
	logic [35:0] refs;
	cdc_eval_type ev;
	int fail_count = 0;
	int checked = 0;
	always #4 ref_clk_in = ~ref_clk_in;
	cdc_sensor_model i_cdc_sensor_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hits_in(hits),
		.odr_tick_out(tick), .eval_out(ev));
	cdc_config i_cdc_config (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .boot_config_pin_in(boot),
		.motion_detect_boot_option_in(mot), .odr_tick_in(tick), .eval_in(ev), .wr_en_in(wr), .rd_en_in(rd),
		.addr_in(addr), .wdata_in(wdata), .outside_source_read_in(osrc), .inside_source_read_in(isrc),
		.rdata_out(rdata), .detector_clk_en_out(clk_en), .outside_event_active_out(oact),
		.inside_event_active_out(iact), .per_axis_outside_flags_out(oflg), .per_axis_inside_flags_out(iflg),
		.reference_out(refs));
	task automatic give_verdict;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic b, input logic m);
		boot = b;
		mot = m;
		rst_in = 1'b1;
		step(4);
		rst_in = 1'b0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(1);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		chk(rdata, e);
		step(1);
	endtask
	// bounded wait for evaluations; a lost tick must not hang the run
	task automatic ticks(input int n);
		int g;
		repeat (n) begin
			g = 0;
			do begin
				@(posedge ref_clk_in);
				g++;
			end while (tick !== 1'b1 && g < 10);
			if (g >= 10) begin
				fail_count++;
				give_verdict();
			end
		end
		#1;
	endtask
	initial begin
		do_reset(1'b1, 1'b1);
		rreg(CDC_CONFIG_A_ADDR, CDC_CONFIG_A_RST_HIGH);
		rreg(CDC_CONFIG_B_ADDR, CDC_CONFIG_B_RST_HIGH);
		chk(clk_en, 1'b1);
		rreg(8'h31, 8'h00);
		do_reset(1'b1, 1'b0);
		rreg(CDC_CONFIG_B_ADDR, 8'h58);
		chk(clk_en, 1'b0);
		do_reset(1'b0, 1'b1);
		rreg(CDC_CONFIG_A_ADDR, 8'h00);
		rreg(CDC_CONFIG_B_ADDR, 8'h00);
		wreg(CDC_CONFIG_B_ADDR, 8'h80);
		step(1);
		chk(refs, 36'h123456789);
		wreg(CDC_CONFIG_A_ADDR, 8'ha0);
		ticks(3);
		hits = 6'h38;
		ticks(1);
		chk(oflg, 3'h4);
		chk(oact, 1'b1);
		hits = 6'h00;
		ticks(1);
		chk(oflg, 3'h4);
		osrc = 1'b1;
		step(1);
		osrc = 1'b0;
		ticks(1);
		chk(oflg, 3'h0);
		wreg(CDC_CONFIG_A_ADDR, 8'h1f);
		ticks(3);
		hits = 6'h3d;
		ticks(1);
		chk(oflg, 3'h3);
		chk(iflg, 3'h5);
		chk(iact, 1'b0);
		hits = 6'h05;
		ticks(1);
		chk(oflg, 3'h0);
		wreg(CDC_CONFIG_B_ADDR, 8'h00);
		step(1);
		chk(clk_en, 1'b0);
		wreg(CDC_CONFIG_B_ADDR, 8'he4);
		ticks(3);
		chk(refs, 36'h0);
		chk(iact, 1'b1);
		hits = 6'h00;
		wreg(CDC_CONFIG_A_ADDR, 8'h43);
		rreg(CDC_CONFIG_A_ADDR, 8'h43);
		ticks(3);
		hits = 6'h06;
		ticks(1);
		chk(iflg, 3'h2);
		chk(iact, 1'b1);
		ticks(1);
		chk(iact, 1'b0);
		hits = 6'h00;
		ticks(1);
		chk(iflg, 3'h2);
		hits = 6'h01;
		wreg(CDC_CONFIG_A_ADDR, 8'h40);
		ticks(1);
		chk(iact, 1'b1);
		chk(iflg, 3'h3);
		isrc = 1'b1;
		step(1);
		isrc = 1'b0;
		ticks(1);
		chk(iflg, 3'h0);
		hits = 6'h07;
		wreg(CDC_CONFIG_A_ADDR, 8'h00);
		ticks(3);
		chk(iact, 1'b0);
		chk(iflg, 3'h0);
		give_verdict();
	end
endmodule
